// file: src/dtu_timer_unit.sv
// Dual 8-bit timer/counter with AHB-Lite register slave.
// Assumes one AHB master, word accesses, pins synchronous to hclk.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dtu_params.svh"

module dtu_timer_unit (
    // AHB-Lite slave
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Timer 0 pins
    input  wire logic              timer0_ext_count_in,
    input  wire logic              timer0_capture_in,
    output logic                   timer0_toggle_out,
    output logic                   timer0_pulse_out,
    // Timer 1 pins
    input  wire logic              timer1_ext_count_in,
    input  wire logic              timer1_capture_in,
    output logic                   timer1_toggle_out,
    output logic                   timer1_pulse_out,
    // Interrupt controller
    input  wire dtu_pkg::dtu_irq_t irq_service,
    output dtu_pkg::dtu_irq_t      irq_request
);
    import dtu_pkg::*;

    // Register map, byte address = 4 * index
    //   b0 timer 0 control: [7] spare, [6:5] mode, [4] clear, [3:0] clock
    //   b1 timer 0 compare data, overwritten by a capture
    //   b2 timer 0 count, read only
    //   b3 timer 1 control, same layout as timer 0
    //   b4 timer 1 compare data
    //   b5 timer 1 count, read only
    //   b6 interrupt enables in [7:4], [3:0] read as zero
    //   b7 interrupt requests in [7:4], a written zero clears
    // Only address bits 9:2 are decoded, so the map repeats above them

    // Index of the register word addressed
    function automatic logic [7:0] word_index(input logic [31:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    // Write strobe for one register in the data phase
    function automatic logic reg_hit(input logic       wr,
                                     input logic [7:0] idx,
                                     input logic [7:0] want);
        reg_hit = wr && (idx == want);
    endfunction : reg_hit

    // Hardware set wins over a service pulse and over a software clear
    function automatic logic flag_next(input logic cur,
                                       input logic wr,
                                       input logic wval,
                                       input logic served,
                                       input logic set);
        flag_next = ((wr ? wval : cur) & ~served) | set;
    endfunction : flag_next

    // Bus address-phase state
    logic       ap_wr;
    logic       next_ap_wr;
    logic [7:0] ap_idx;
    logic [7:0] next_ap_idx;
    logic [7:0] rd_byte;
    logic [7:0] next_rd_byte;
    logic       access;
    logic [7:0] wbyte;

    // Shared interrupt enable
    logic [3:0] irq_enable_high;
    logic [3:0] next_irq_enable_high;
    logic       en_wr;
    logic       req_wr;

    // Transfer size is not decoded; every access is taken as a whole word
    assign wbyte     = hwdata[7:0];
    assign en_wr     = reg_hit(ap_wr, ap_idx, `DTU_IDX_IRQ_EN);
    assign req_wr    = reg_hit(ap_wr, ap_idx, `DTU_IDX_IRQ_REQ);
    // No wait states and no error answer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // One copy per timer; timer 1 is t = 1
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        // Register indexes and interrupt bit positions of this timer
        localparam logic [7:0] CTRL_IDX  = t ? `DTU_IDX_T1_CTRL : `DTU_IDX_T0_CTRL;
        localparam logic [7:0] DATA_IDX  = t ? `DTU_IDX_T1_DATA : `DTU_IDX_T0_DATA;
        localparam logic [7:0] DATA_RST  = t ? `DTU_T1_DATA_RST : `DTU_T0_DATA_RST;
        localparam int         MATCH_BIT = 3 - 2 * t;
        localparam int         OVF_BIT   = 2 - 2 * t;

        logic [7:0] ctrl;
        logic [7:0] next_ctrl;
        logic [7:0] data;
        logic [7:0] next_data;
        logic [7:0] buffer;
        logic [7:0] next_buffer;
        logic [7:0] count;
        logic [7:0] next_count;
        logic       toggle;
        logic       next_toggle;
        logic       pulse;
        logic       next_pulse;
        logic       cap_prev;
        logic       next_cap_prev;
        logic       mflag;
        logic       next_mflag;
        logic       oflag;
        logic       next_oflag;
        logic       tick;
        logic       ext_in;
        logic       cap_in;
        logic       ctrl_wr;
        logic       data_wr;
        logic       clear;
        logic       match;
        logic       ovf;
        logic       cap_evt;
        logic       capturing;
        dtu_mode_t  mode;

        assign ext_in  = t ? timer1_ext_count_in : timer0_ext_count_in;
        assign cap_in  = t ? timer1_capture_in : timer0_capture_in;
        assign ctrl_wr = reg_hit(ap_wr, ap_idx, CTRL_IDX);
        assign data_wr = reg_hit(ap_wr, ap_idx, DATA_IDX);
        assign clear   = ctrl_wr && wbyte[`DTU_CLEAR_BIT];

        // Count source: prescaled system clock or external pin edge
        dtu_tick_gen #(
            .SHIFT_LESS (t == 1)
        ) u_tick (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .clock_select (ctrl[`DTU_CS_HI:`DTU_CS_LO]),
            .ext_count_in (ext_in),
            .tick         (tick)
        );

        always_comb begin
            mode      = dtu_mode_t'(ctrl[`DTU_MODE_HI:`DTU_MODE_LO]);
            capturing = ctrl[`DTU_MODE_HI];
            // Low mode bit doubles as the capture edge choice
            if (ctrl[`DTU_EDGE_BIT]) begin
                cap_evt = capturing && !cap_in && cap_prev;
            end else begin
                cap_evt = capturing && cap_in && !cap_prev;
            end
            // Compare is idle while capturing, as capture owns the count
            match = tick && !capturing && (count == buffer);
            // No overflow event in interval mode
            ovf   = tick && (mode != DTU_MODE_INTERVAL)
                    && (count == `DTU_COUNT_MAX);
        end

        // Next state of this timer, driven by the events above
        always_comb begin
            next_ctrl     = ctrl;
            next_data     = data;
            next_buffer   = buffer;
            next_count    = count;
            next_toggle   = toggle;
            next_cap_prev = cap_in;

            if (ctrl_wr) begin
                next_ctrl = wbyte & ~(8'h01 << `DTU_CLEAR_BIT);
            end
            if (data_wr) begin
                next_data = wbyte;
            end

            // Capture beats clear, clear beats a match, an interval-mode match beats a tick
            if (cap_evt) begin
                next_data  = count;
                next_count = `DTU_COUNT_RST;
            end else if (clear) begin
                next_count = `DTU_COUNT_RST;
            end else if (match && (mode == DTU_MODE_INTERVAL)) begin
                next_count = `DTU_COUNT_RST;
            end else if (tick) begin
                next_count = count + 8'h01;
            end

            // Software sees data; the comparator sees only the buffer, so
            // a new compare value waits for the next clear, match or wrap
            if (clear || match || ovf) begin
                next_buffer = data;
            end
            if (match && (mode == DTU_MODE_INTERVAL)) begin
                next_toggle = ~toggle;
            end
            // Judged on the values being loaded, mode included, so the pin
            // lines up with the count from the first cycle of a mode
            next_pulse = (next_ctrl[`DTU_MODE_HI:`DTU_MODE_LO] == DTU_MODE_PWM)
                         && (next_buffer > next_count);

            // Flags are set by events, cleared by service or a written zero
            next_mflag = flag_next(mflag, req_wr, wbyte[`DTU_IRQ_LSB + MATCH_BIT],
                                   irq_service[MATCH_BIT], match);
            next_oflag = flag_next(oflag, req_wr, wbyte[`DTU_IRQ_LSB + OVF_BIT],
                                   irq_service[OVF_BIT], ovf);
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl     <= `DTU_CTRL_RST;
                data     <= DATA_RST;
                buffer   <= DATA_RST;
                count    <= `DTU_COUNT_RST;
                toggle   <= 1'b0;
                pulse    <= 1'b0;
                cap_prev <= 1'b0;
                mflag    <= 1'b0;
                oflag    <= 1'b0;
            end else begin
                ctrl     <= next_ctrl;
                data     <= next_data;
                buffer   <= next_buffer;
                count    <= next_count;
                toggle   <= next_toggle;
                pulse    <= next_pulse;
                cap_prev <= next_cap_prev;
                mflag    <= next_mflag;
                oflag    <= next_oflag;
            end
        end
    end

    assign timer0_toggle_out = g_tmr[0].toggle;
    assign timer0_pulse_out  = g_tmr[0].pulse;
    assign timer1_toggle_out = g_tmr[1].toggle;
    assign timer1_pulse_out  = g_tmr[1].pulse;

    // Requests reach the processor only when enabled
    always_comb begin
        irq_request.t0_match = g_tmr[0].mflag & irq_enable_high[3];
        irq_request.t0_ovf   = g_tmr[0].oflag & irq_enable_high[2];
        irq_request.t1_match = g_tmr[1].mflag & irq_enable_high[1];
        irq_request.t1_ovf   = g_tmr[1].oflag & irq_enable_high[0];
    end

    // Enables live in the upper nibble of their register
    always_comb begin
        next_irq_enable_high = irq_enable_high;
        if (en_wr) begin
            next_irq_enable_high = wbyte[7:`DTU_IRQ_LSB];
        end
    end

    // Read data sampled from next values so a read right behind a
    // write to the same register sees the written value
    always_comb begin
        access       = hsel && htrans[1] && hready;
        next_ap_wr   = access && hwrite;
        next_ap_idx  = word_index(haddr);
        next_rd_byte = 8'h00;
        if (access && !hwrite) begin
            unique case (word_index(haddr))
                `DTU_IDX_T0_CTRL:  next_rd_byte = g_tmr[0].next_ctrl;
                `DTU_IDX_T0_DATA:  next_rd_byte = g_tmr[0].next_data;
                `DTU_IDX_T0_COUNT: next_rd_byte = g_tmr[0].next_count;
                `DTU_IDX_T1_CTRL:  next_rd_byte = g_tmr[1].next_ctrl;
                `DTU_IDX_T1_DATA:  next_rd_byte = g_tmr[1].next_data;
                `DTU_IDX_T1_COUNT: next_rd_byte = g_tmr[1].next_count;
                `DTU_IDX_IRQ_EN:   next_rd_byte = {next_irq_enable_high, 4'h0};
                `DTU_IDX_IRQ_REQ:  next_rd_byte = {g_tmr[0].next_mflag,
                                                   g_tmr[0].next_oflag,
                                                   g_tmr[1].next_mflag,
                                                   g_tmr[1].next_oflag, 4'h0};
                // Unmapped indexes read as zero
                default:           next_rd_byte = 8'h00;
            endcase
        end
    end

    // Address phase is held for the data phase, where writes land
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr           <= 1'b0;
            ap_idx          <= 8'h00;
            rd_byte         <= 8'h00;
            irq_enable_high <= `DTU_IRQ_RST;
        end else begin
            ap_wr           <= next_ap_wr;
            ap_idx          <= next_ap_idx;
            rd_byte         <= next_rd_byte;
            irq_enable_high <= next_irq_enable_high;
        end
    end

    // Registers are one byte wide; upper read bytes stay zero
    assign hrdata = {24'h00_0000, rd_byte};

endmodule : dtu_timer_unit
`default_nettype wire

// file: pkg/dtu_params.svh
// Constants for the dual 8-bit timer unit: register indexes, fields,
// reset values and clock select codes.
// Assumes an AHB-Lite slave where byte address = 4 * register index.
`ifndef DTU_PARAMS_SVH
`define DTU_PARAMS_SVH

`define DTU_IDX_T0_CTRL   8'hb0
`define DTU_IDX_T0_DATA   8'hb1
`define DTU_IDX_T0_COUNT  8'hb2
`define DTU_IDX_T1_CTRL   8'hb3
`define DTU_IDX_T1_DATA   8'hb4
`define DTU_IDX_T1_COUNT  8'hb5
`define DTU_IDX_IRQ_EN    8'hb6
`define DTU_IDX_IRQ_REQ   8'hb7

`define DTU_CLEAR_BIT     4
`define DTU_MODE_HI       6
`define DTU_MODE_LO       5
`define DTU_EDGE_BIT      5
`define DTU_CS_HI         3
`define DTU_CS_LO         0

`define DTU_CTRL_RST      8'h00
`define DTU_T0_DATA_RST   8'h00
`define DTU_T1_DATA_RST   8'hff
`define DTU_COUNT_RST     8'h00
`define DTU_COUNT_MAX     8'hff
`define DTU_IRQ_RST       4'h0
`define DTU_IRQ_LSB       4

`define DTU_CS_EXT_RISE   4'h5
`define DTU_CS_EXT_FALL   4'h6
`define DTU_PRESC_W       11

`endif

// file: pkg/dtu_pkg.sv
// Types shared by the dual 8-bit timer unit.
// Assumes dtu_params.svh is on the include path.
package dtu_pkg;

    typedef enum logic [1:0] {
        DTU_MODE_INTERVAL = 2'b00,
        DTU_MODE_PWM      = 2'b01,
        DTU_MODE_CAP_RISE = 2'b10,
        DTU_MODE_CAP_FALL = 2'b11
    } dtu_mode_t;

    // Order matches request/enable bits 7 down to 4
    typedef struct packed {
        logic t0_match;
        logic t0_ovf;
        logic t1_match;
        logic t1_ovf;
    } dtu_irq_t;

endpackage : dtu_pkg

// file: src/dtu_tick_gen.sv
// Count clock source for one timer: free prescaler or external pin edge.
// Assumes the external pin is already synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "dtu_params.svh"

module dtu_tick_gen #(
    parameter logic SHIFT_LESS = 1'b0
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] clock_select,
    input  wire logic       ext_count_in,
    output logic            tick
);
    import dtu_pkg::*;

    logic [`DTU_PRESC_W-1:0] presc;
    logic [`DTU_PRESC_W-1:0] next_presc;
    logic [`DTU_PRESC_W-1:0] mask;
    logic                    ext_prev;
    logic                    next_ext_prev;
    logic [3:0]              shift;

    // Log2 of divisor for codes 1000..1111 (timer 0 table)
    function automatic logic [3:0] div_shift(input logic [2:0] code);
        unique case (code)
            3'h0: div_shift = 4'h1;
            3'h1: div_shift = 4'h2;
            3'h2: div_shift = 4'h3;
            3'h3: div_shift = 4'h4;
            3'h4: div_shift = 4'h5;
            3'h5: div_shift = 4'h7;
            3'h6: div_shift = 4'h9;
            3'h7: div_shift = 4'hb;
        endcase
    endfunction : div_shift

    always_comb begin
        next_presc    = presc + `DTU_PRESC_W'(1);
        next_ext_prev = ext_count_in;
        // Timer 1 table is one octave faster than timer 0
        shift = div_shift(clock_select[2:0]) - {3'h0, SHIFT_LESS};
        mask  = `DTU_PRESC_W'((12'h001 << shift) - 12'h001);
        tick  = 1'b0;
        if (clock_select[3]) begin
            tick = (presc & mask) == mask;
        end else if (clock_select == `DTU_CS_EXT_RISE) begin
            tick = ext_count_in & ~ext_prev;
        end else if (clock_select == `DTU_CS_EXT_FALL) begin
            tick = ~ext_count_in & ext_prev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc    <= '0;
            ext_prev <= 1'b0;
        end else begin
            presc    <= next_presc;
            ext_prev <= next_ext_prev;
        end
    end

endmodule : dtu_tick_gen
`default_nettype wire

// file: bench/dtu_timer_unit_asserts.sv
// Checker for the timer unit: bus answer, interrupt gating and service.
// Assumes it is bound to dtu_timer_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dtu_params.svh"
module dtu_timer_unit_asserts (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hwdata,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              timer0_toggle_out,
    input wire logic              timer1_toggle_out,
    input wire dtu_pkg::dtu_irq_t irq_service,
    input wire dtu_pkg::dtu_irq_t irq_request
);
    import dtu_pkg::*;
    // Shadow of the enable register, so gating is judged at the ports
    logic       wr_pend;
    logic       next_wr_pend;
    logic [3:0] en;
    logic [3:0] next_en;
    logic       rd_take;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    always_comb begin
        next_wr_pend = hsel && htrans[1] && hready && hwrite
                       && haddr[9:2] == `DTU_IDX_IRQ_EN;
        next_en = en;
        if (wr_pend) begin
            next_en = hwdata[7:4];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            en      <= 4'h0;
        end else begin
            wr_pend <= next_wr_pend;
            en      <= next_en;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready OKAY");
    chk_rdata_wide: assert property (hrdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    chk_rdata_idle: assert property (!rd_take |=> hrdata == 32'h0)
        else $error("read data left standing");
    chk_t0m_gate: assert property (irq_request.t0_match |-> en[3])
        else $error("timer0 match request while disabled");
    chk_t0o_gate: assert property (irq_request.t0_ovf |-> en[2])
        else $error("timer0 overflow request while disabled");
    chk_t0m_serv: assert property (irq_service.t0_match |=>
        !irq_request.t0_match || $changed(timer0_toggle_out))
        else $error("timer0 match flag kept after service");
    chk_t0o_serv: assert property (irq_service.t0_ovf |=> !irq_request.t0_ovf)
        else $error("timer0 overflow flag kept after service");
    chk_t0_toggle: assert property ($changed(timer0_toggle_out) && en[3]
        |-> irq_request.t0_match)
        else $error("timer0 toggle without match request");
    chk_t1_toggle: assert property ($changed(timer1_toggle_out) && en[1]
        |-> irq_request.t1_match)
        else $error("timer1 toggle without match request");
endmodule : dtu_timer_unit_asserts
bind dtu_timer_unit dtu_timer_unit_asserts chk_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .timer0_toggle_out, .timer1_toggle_out, .irq_service, .irq_request);
`default_nettype wire

// file: bench/dtu_timer_unit_tb.sv
// Self-checking bench: registers, interval, PWM, capture, timer 1.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "dtu_params.svh"
module dtu_timer_unit_tb;
    import dtu_pkg::*;
    logic        hclk, hresetn, htrans1, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic        cnt_in0, cap_in0, cnt_in1, cap_in1, tog0, pwm0, tog1, pwm1;
    dtu_irq_t    svc, req;
    int          fails, num_checks, cyc;
    dtu_timer_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans({htrans1, 1'b0}), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timer0_ext_count_in(cnt_in0), .timer0_capture_in(cap_in0),
        .timer0_toggle_out(tog0), .timer0_pulse_out(pwm0),
        .timer1_ext_count_in(cnt_in1), .timer1_capture_in(cap_in1),
        .timer1_toggle_out(tog1), .timer1_pulse_out(pwm1),
        .irq_service(svc), .irq_request(req));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // One single word transfer; waits on ready, never on a cycle count
    task automatic bus(input bit w, input logic [7:0] i, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        htrans1 <= 1'b1;
        haddr   <= {22'h0, i, 2'b00};
        hwrite  <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans1 <= 1'b0;
        hwdata  <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, i, 32'h0, q);
        cmp(q, e);
    endtask : rdc
    task automatic kick(input bit t, input int n);
        repeat (n) begin
            @(posedge hclk);
            {cnt_in1, cnt_in0} <= t ? 2'b10 : 2'b01;
            @(posedge hclk);
            {cnt_in1, cnt_in0} <= 2'b00;
        end
        repeat (3) @(posedge hclk);
    endtask : kick
    task automatic serve(input dtu_irq_t m);
        @(posedge hclk);
        svc <= m;
        @(posedge hclk);
        svc <= 4'h0;
        #1;
    endtask : serve
    // Start one step late so an update at the calling edge is not counted as a change
    task automatic wait_chg(input int s, output int at);
        logic v;
        int   n;
        #1;
        v = (s == 0) ? tog0 : pwm0;
        n = 0;
        while (((s == 0) ? tog0 : pwm0) === v && n < 1000) begin
            @(posedge hclk);
            #1;
            n++;
        end
        cmp(32'(n < 1000), 32'h1);
        at = cyc;
    endtask : wait_chg
    task automatic t_regs;
        rdc(`DTU_IDX_T0_CTRL, 32'h0);
        rdc(`DTU_IDX_T0_DATA, 32'h0);
        rdc(`DTU_IDX_T1_DATA, 32'hff);
        rdc(`DTU_IDX_IRQ_REQ, 32'h0);
        rdc(8'hc0, 32'h0);
        wr(`DTU_IDX_T0_DATA, 32'h5a);
        rdc(`DTU_IDX_T0_DATA, 32'h5a);
        wr(`DTU_IDX_T0_COUNT, 32'h77);
        rdc(`DTU_IDX_T0_COUNT, 32'h0);
    endtask : t_regs
    task automatic t_interval;
        int a, b, c;
        wr(`DTU_IDX_IRQ_EN, 32'h80);
        wr(`DTU_IDX_T0_DATA, 32'h3);
        wr(`DTU_IDX_T0_CTRL, 32'h18);
        rdc(`DTU_IDX_T0_CTRL, 32'h8);
        wait_chg(0, a);
        cmp(32'(req.t0_match), 32'h1);
        wr(`DTU_IDX_T0_DATA, 32'h5);
        wait_chg(0, b);
        cmp(32'(b - a), 32'd8);
        wait_chg(0, c);
        cmp(32'(c - b), 32'd12);
        serve(4'b1000);
        cmp(32'(req.t0_match), 32'h0);
        wr(`DTU_IDX_T0_CTRL, 32'h0);
    endtask : t_interval
    task automatic t_pwm;
        int a, b, c;
        wr(`DTU_IDX_IRQ_EN, 32'h40);
        wr(`DTU_IDX_T0_DATA, 32'h10);
        wr(`DTU_IDX_T0_CTRL, 32'h38);
        repeat (2) wait_chg(2, a);
        wait_chg(2, b);
        cmp(32'(b - a), 32'd32);
        wait_chg(2, c);
        cmp(32'(c - a), 32'd512);
        cmp(32'(req), 32'h4);
        serve(4'b0100);
        cmp(32'(req), 32'h0);
        wr(`DTU_IDX_IRQ_EN, 32'hc0);
        #1;
        cmp(32'(req), 32'h8);
        wr(`DTU_IDX_T0_CTRL, 32'h0);
        wr(`DTU_IDX_IRQ_EN, 32'h0);
    endtask : t_pwm
    task automatic t_capture;
        wr(`DTU_IDX_T0_CTRL, 32'h55);
        kick(1'b0, 5);
        rdc(`DTU_IDX_T0_COUNT, 32'h5);
        @(posedge hclk);
        cap_in0 <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(`DTU_IDX_T0_DATA, 32'h5);
        rdc(`DTU_IDX_T0_COUNT, 32'h0);
        wr(`DTU_IDX_T0_CTRL, 32'h76);
        kick(1'b0, 3);
        @(posedge hclk);
        cap_in0 <= 1'b0;
        repeat (2) @(posedge hclk);
        rdc(`DTU_IDX_T0_DATA, 32'h3);
    endtask : t_capture
    task automatic t_timer1;
        kick(1'b1, 2);
        rdc(`DTU_IDX_T1_COUNT, 32'h0);
        wr(`DTU_IDX_IRQ_EN, 32'h20);
        wr(`DTU_IDX_T1_DATA, 32'h2);
        wr(`DTU_IDX_T1_CTRL, 32'h15);
        kick(1'b1, 3);
        cmp(32'(tog1), 32'h1);
        cmp(32'(req), 32'h2);
        rdc(`DTU_IDX_T1_COUNT, 32'h0);
        wr(`DTU_IDX_T1_CTRL, 32'h35);
        #1;
        cmp(32'(pwm1), 32'h1);
        kick(1'b1, 2);
        cmp(32'(pwm1), 32'h0);
    endtask : t_timer1
    initial begin
        #200_000;
        fails++;
        close_out();
    end
    initial begin
        {hresetn, htrans1, hwrite, cnt_in0, cap_in0, cnt_in1, cap_in1} = 7'h0;
        {haddr, hwdata} = 64'h0;
        svc = 4'h0;
        {fails, num_checks} = 64'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_interval();
        t_pwm();
        t_capture();
        t_timer1();
        close_out();
    end
endmodule : dtu_timer_unit_tb
`default_nettype wire
